/* verilog/pshp_top.sv */
// Parallel slave host port with APB register access
//
// Notes on behaviour
// RULE_01: Host write sets input pending flag
// RULE_02: Output pending until host reads byte
// RULE_03: Write while pending sets sticky overrun
// RULE_04: Select bit picks host port or GPIO
// RULE_05: Low three bits set control pin directions
// RULE_06: Low read strobe with select reads latch
// RULE_07: Low write strobe with select writes latch
// RULE_08: Low select pin selects the device
// RULE_09: Write starts at first low select+write
// RULE_10: Read starts at first low select+read
// RULE_11: Software sets control pins as inputs
// RULE_12: Software sets control pins digital
// RULE_13: Host access asynchronous, strobes qualify
// RULE_14: Eight data bits in parallel
// RULE_15: Select bit makes control pins inputs
// RULE_16: Completed host transfer raises interrupt flag
// RULE_17: CPU read clears input, write sets output
// RULE_18: Host read drives latch while strobes low
`timescale 1ns/1ps
`default_nettype none
module pshp_top
    import pshp_pkg::*;
(
    // Clock and reset
    input  wire logic                       mclk,
    input  wire logic                       srst,
    // APB slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [pshp_pkg::PSHP_ADDR_W-1:0] paddr,
    input  wire logic [pshp_pkg::PSHP_DATA_W-1:0] pwdata,
    output logic      [pshp_pkg::PSHP_DATA_W-1:0] prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Interrupt
    output logic                            irq,
    // Eight-bit data pins
    input  wire logic [7:0]                 data_pin_in,
    output logic      [7:0]                 data_pin_out,
    output logic      [7:0]                 data_pin_oe,
    // Control pins: read, write, select
    input  wire logic [2:0]                 ctrl_pin_in,
    output logic      [2:0]                 ctrl_pin_out,
    output logic      [2:0]                 ctrl_pin_oe
);

    // Registers
    logic [7:0]  out_latch_r;
    logic [7:0]  in_latch_r;
    logic [2:0]  ctrl_latch_r;
    logic [7:0]  data_dir_r;
    logic [2:0]  ctrl_dir_r;
    logic        port_select_r;
    logic        in_pending_r;
    logic        out_pending_r;
    logic        in_overrun_r;
    logic        irq_flag_r;
    logic        irq_enable_r;
    logic [7:0]  conv_cfg_r;

    // Bus outputs
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        irq_r;
    logic [7:0]  data_out_r;
    logic [7:0]  data_oe_r;
    logic [2:0]  ctrl_out_r;
    logic [2:0]  ctrl_oe_r;

    // Synchronised pins
    logic [7:0]  data_s;
    logic [2:0]  ctrl_s;

    // Host events
    logic        rd_active;
    logic        rd_start;
    logic        rd_done;
    logic        wr_active;
    logic        wr_start;
    logic        wr_done;

    // Bus decode
    logic [9:0]  reg_idx;
    logic        acc_phase;
    logic        bus_done;
    logic        bus_wr;
    logic        bus_rd;
    logic        hit;
    logic [7:0]  rd_mux;
    logic [7:0]  wbyte;
    logic [7:0]  status_byte;

    // Register decode is used both for the read path and for the error answer
    function automatic logic idx_mapped(input logic [9:0] idx);
        return idx == PSHP_IDX_DATA_PORT_LATCH  || idx == PSHP_IDX_CONTROL_PIN_PORT ||
               idx == PSHP_IDX_IRQ_FLAGS_1      || idx == PSHP_IDX_DATA_PORT_DIR    ||
               idx == PSHP_IDX_DIR_HOST_STATUS  || idx == PSHP_IDX_IRQ_ENABLES_1    ||
               idx == PSHP_IDX_CONVERTER_CONFIG;
    endfunction

    // Host pins come from another timing world
    pshp_sync #(.WIDTH(8), .RST_LEVEL(1'b0)) u_data_sync ( // RULE_13
        .mclk     (mclk),
        .srst     (srst),
        .async_in (data_pin_in),
        .sync_out (data_s)
    );

    pshp_sync #(.WIDTH(3), .RST_LEVEL(1'b1)) u_ctrl_sync ( // RULE_13
        .mclk     (mclk),
        .srst     (srst),
        .async_in (ctrl_pin_in),
        .sync_out (ctrl_s)
    );

    // Select low qualifies both strobes
    pshp_strobe u_rd_strobe ( // RULE_06 RULE_08 RULE_10
        .mclk     (mclk),
        .srst     (srst),
        .select_n (ctrl_s[PSHP_PIN_SELECT]),
        .strobe_n (ctrl_s[PSHP_PIN_READ]),
        .enable   (port_select_r),
        .active   (rd_active),
        .start    (rd_start),
        .done     (rd_done)
    );

    pshp_strobe u_wr_strobe ( // RULE_07 RULE_08 RULE_09
        .mclk     (mclk),
        .srst     (srst),
        .select_n (ctrl_s[PSHP_PIN_SELECT]),
        .strobe_n (ctrl_s[PSHP_PIN_WRITE]),
        .enable   (port_select_r),
        .active   (wr_active),
        .start    (wr_start),
        .done     (wr_done)
    );

    assign reg_idx   = paddr[11:2];
    assign acc_phase = psel & penable;
    assign bus_done  = acc_phase & pready_r;
    assign hit       = idx_mapped(reg_idx);
    assign bus_wr    = bus_done & pwrite & hit;
    assign bus_rd    = bus_done & ~pwrite & hit;
    assign wbyte     = pwdata[7:0];

    assign status_byte = {in_pending_r, out_pending_r, in_overrun_r, port_select_r,
                          1'b0, ctrl_dir_r};

    // Read mux; in host mode the latch reads the byte the host wrote
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_idx)
            PSHP_IDX_DATA_PORT_LATCH:  rd_mux = port_select_r ? in_latch_r : data_s;
            PSHP_IDX_CONTROL_PIN_PORT: rd_mux = {5'h00, ctrl_s};
            PSHP_IDX_IRQ_FLAGS_1:      rd_mux = {irq_flag_r, 7'h00};
            PSHP_IDX_DATA_PORT_DIR:    rd_mux = data_dir_r;
            PSHP_IDX_DIR_HOST_STATUS:  rd_mux = status_byte;
            PSHP_IDX_IRQ_ENABLES_1:    rd_mux = {irq_enable_r, 7'h00};
            PSHP_IDX_CONVERTER_CONFIG: rd_mux = conv_cfg_r;
            default:                   rd_mux = 8'h00;
        endcase
    end

    // APB answer: one wait state, data and error registered before completion
    always_ff @(posedge mclk) begin
        if (srst) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (acc_phase & ~pready_r) begin
            pready_r  <= 1'b1;
            prdata_r  <= {24'h00_0000, rd_mux};
            pslverr_r <= ~hit;
        end else begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    // Mode select and direction bits; status bits above are read only except overrun, which software clears by writing zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            port_select_r <= PSHP_RST_DIR_HOST_STATUS[PSHP_BIT_PORT_SELECT];
            ctrl_dir_r    <= PSHP_RST_DIR_HOST_STATUS[2:0];
        end else if (bus_wr && reg_idx == PSHP_IDX_DIR_HOST_STATUS) begin
            port_select_r <= wbyte[PSHP_BIT_PORT_SELECT]; // RULE_04
            ctrl_dir_r    <= wbyte[2:0]; // RULE_05
        end
    end

    // Plain storage registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            data_dir_r   <= PSHP_RST_DATA_PORT_DIR;
            ctrl_latch_r <= PSHP_RST_CONTROL_LATCH;
            conv_cfg_r   <= PSHP_RST_CONVERTER_CONFIG;
            irq_enable_r <= PSHP_RST_IRQ_ENABLES_1[PSHP_BIT_HOST_IRQ];
        end else if (bus_wr) begin
            if (reg_idx == PSHP_IDX_DATA_PORT_DIR) begin
                data_dir_r <= wbyte;
            end
            if (reg_idx == PSHP_IDX_CONTROL_PIN_PORT) begin
                ctrl_latch_r <= wbyte[2:0];
            end
            if (reg_idx == PSHP_IDX_CONVERTER_CONFIG) begin
                conv_cfg_r <= wbyte;
            end
            if (reg_idx == PSHP_IDX_IRQ_ENABLES_1) begin
                irq_enable_r <= wbyte[PSHP_BIT_HOST_IRQ];
            end
        end
    end

    // CPU side of the output latch and its pending flag
    always_ff @(posedge mclk) begin
        if (srst) begin
            out_latch_r   <= PSHP_RST_DATA_LATCH;
            out_pending_r <= 1'b0;
        end else if (bus_wr && reg_idx == PSHP_IDX_DATA_PORT_LATCH) begin
            out_latch_r   <= wbyte;
            out_pending_r <= port_select_r; // RULE_17
        end else if (rd_start) begin
            out_pending_r <= 1'b0; // RULE_02
        end
    end

    // Host write captures all eight bits; a new byte beats a CPU read clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_latch_r   <= PSHP_RST_DATA_LATCH;
            in_pending_r <= 1'b0;
        end else if (wr_start) begin
            in_latch_r   <= data_s; // RULE_14
            in_pending_r <= 1'b1; // RULE_01
        end else if (bus_rd && reg_idx == PSHP_IDX_DATA_PORT_LATCH && port_select_r) begin
            in_pending_r <= 1'b0; // RULE_17
        end
    end

    // Overrun stays until software writes it to zero; a new overrun wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            in_overrun_r <= PSHP_RST_DIR_HOST_STATUS[PSHP_BIT_IN_OVERRUN];
        end else if (wr_start && in_pending_r) begin
            in_overrun_r <= 1'b1; // RULE_03
        end else if (bus_wr && reg_idx == PSHP_IDX_DIR_HOST_STATUS) begin
            in_overrun_r <= in_overrun_r & wbyte[PSHP_BIT_IN_OVERRUN];
        end
    end

    // Sticky transfer flag, write one to clear, set wins over clear
    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_flag_r <= PSHP_RST_IRQ_FLAGS_1[PSHP_BIT_HOST_IRQ];
        end else if (rd_done || wr_done) begin
            irq_flag_r <= 1'b1; // RULE_16
        end else if (bus_wr && reg_idx == PSHP_IDX_IRQ_FLAGS_1 && wbyte[PSHP_BIT_HOST_IRQ]) begin
            irq_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_flag_r & irq_enable_r; // RULE_16
        end
    end

    // Pin drivers; host read data lags the strobes by the synchroniser delay plus one register
    always_ff @(posedge mclk) begin
        if (srst) begin
            data_out_r <= PSHP_RST_DATA_LATCH;
            data_oe_r  <= 8'h00;
            ctrl_out_r <= PSHP_RST_CONTROL_LATCH;
            ctrl_oe_r  <= 3'h0;
        end else begin
            data_out_r <= out_latch_r;
            ctrl_out_r <= ctrl_latch_r;
            if (port_select_r) begin
                data_oe_r <= {8{rd_active}}; // RULE_18
                ctrl_oe_r <= 3'h0; // RULE_15
            end else begin
                data_oe_r <= ~data_dir_r;
                ctrl_oe_r <= ~ctrl_dir_r; // RULE_05
            end
        end
    end

    assign prdata       = prdata_r;
    assign pready       = pready_r;
    assign pslverr      = pslverr_r;
    assign irq          = irq_r;
    assign data_pin_out = data_out_r;
    assign data_pin_oe  = data_oe_r;
    assign ctrl_pin_out = ctrl_out_r;
    assign ctrl_pin_oe  = ctrl_oe_r;

endmodule
`default_nettype wire

/* verilog/pshp_pkg.sv */
// Package: register map, field positions and reset values of the host slave port
package pshp_pkg;

    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] PSHP_IDX_DATA_PORT_LATCH   = 10'h008;
    localparam logic [9:0] PSHP_IDX_CONTROL_PIN_PORT  = 10'h009;
    localparam logic [9:0] PSHP_IDX_IRQ_FLAGS_1       = 10'h00C;
    localparam logic [9:0] PSHP_IDX_DATA_PORT_DIR     = 10'h088;
    localparam logic [9:0] PSHP_IDX_DIR_HOST_STATUS   = 10'h089;
    localparam logic [9:0] PSHP_IDX_IRQ_ENABLES_1     = 10'h08C;
    localparam logic [9:0] PSHP_IDX_CONVERTER_CONFIG  = 10'h09F;

    localparam int PSHP_ADDR_W = 12;
    localparam int PSHP_DATA_W = 32;

    // Direction and host status field positions
    localparam int PSHP_BIT_IN_PENDING   = 7;
    localparam int PSHP_BIT_OUT_PENDING  = 6;
    localparam int PSHP_BIT_IN_OVERRUN   = 5;
    localparam int PSHP_BIT_PORT_SELECT  = 4;
    localparam int PSHP_BIT_DIR_SELECT   = 2;
    localparam int PSHP_BIT_DIR_WRITE    = 1;
    localparam int PSHP_BIT_DIR_READ     = 0;

    // Interrupt flag and enable position
    localparam int PSHP_BIT_HOST_IRQ     = 7;

    // Control pin positions on the three-pin port
    localparam int PSHP_PIN_READ         = 0;
    localparam int PSHP_PIN_WRITE        = 1;
    localparam int PSHP_PIN_SELECT       = 2;

    // Values after reset
    localparam logic [7:0] PSHP_RST_DIR_HOST_STATUS  = 8'h07;
    localparam logic [7:0] PSHP_RST_IRQ_FLAGS_1      = 8'h00;
    localparam logic [7:0] PSHP_RST_IRQ_ENABLES_1    = 8'h00;
    localparam logic [7:0] PSHP_RST_CONVERTER_CONFIG = 8'h00;
    localparam logic [7:0] PSHP_RST_DATA_PORT_DIR    = 8'hFF;
    localparam logic [7:0] PSHP_RST_DATA_LATCH       = 8'h00;
    localparam logic [2:0] PSHP_RST_CONTROL_LATCH    = 3'h0;

    // Synchroniser depth for pin inputs
    localparam int PSHP_SYNC_STAGES = 2;

endpackage

/* verilog/pshp_sync.sv */
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module pshp_sync #(
    parameter int         WIDTH     = 8,
    parameter logic [0:0] RST_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             srst,
    // Pin side
    input  wire logic [WIDTH-1:0] async_in,
    // Clock domain side
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // The first stage feeds only the second stage
    always_ff @(posedge mclk) begin
        if (srst) begin
            meta_r <= {WIDTH{RST_LEVEL}};
            sync_r <= {WIDTH{RST_LEVEL}};
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule
`default_nettype wire

/* verilog/pshp_strobe.sv */
// Host strobe detector: active level, start pulse and end pulse of one strobe
`timescale 1ns/1ps
`default_nettype none
module pshp_strobe (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic srst,
    // Synchronised pins, active low; enable is active high
    input  wire logic select_n,
    input  wire logic strobe_n,
    input  wire logic enable,
    // Transfer events
    output logic      active,
    output logic      start,
    output logic      done
);

    logic active_r;

    assign active = enable & ~select_n & ~strobe_n;

    always_ff @(posedge mclk) begin
        if (srst) begin
            active_r <= 1'b0;
        end else begin
            active_r <= active;
        end
    end

    // Start on the first sample with both lines low
    assign start = active & ~active_r;
    assign done  = ~active & active_r;

endmodule
`default_nettype wire

/* test/pshp_assertions.sv */
// Port-level checker for the parallel host slave port
`timescale 1ns/1ps
`default_nettype none
module pshp_assertions
    import pshp_pkg::*;
(
    // Clock and reset
    input wire logic                                mclk,
    input wire logic                                srst,
    // APB
    input wire logic                                psel,
    input wire logic                                penable,
    input wire logic                                pwrite,
    input wire logic [pshp_pkg::PSHP_DATA_W-1:0]    prdata,
    input wire logic                                pready,
    input wire logic                                pslverr,
    // Interrupt and pins
    input wire logic                                irq,
    input wire logic [7:0]                          data_pin_out,
    input wire logic [7:0]                          data_pin_oe,
    input wire logic [2:0]                          ctrl_pin_in,
    input wire logic [2:0]                          ctrl_pin_out
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // Recent causes: register writes, select low, select with read strobe low
    logic [7:0] wr_hist_r;
    logic [7:0] sel_hist_r;
    logic [7:0] rd_hist_r;
    always_ff @(posedge mclk) wr_hist_r <= srst ? 8'h00 : {wr_hist_r[6:0], psel & penable & pready & pwrite};
    always_ff @(posedge mclk) sel_hist_r <= srst ? 8'h00 : {sel_hist_r[6:0], ~ctrl_pin_in[2]};
    always_ff @(posedge mclk) rd_hist_r <= srst ? 8'h00 : {rd_hist_r[6:0], ~ctrl_pin_in[2] & ~ctrl_pin_in[0]};

    property p_ready_after_access;
        $rose(psel && penable) |=> pready;
    endproperty
    a_ready_after_access: assert property (p_ready_after_access) else $error("pready late");

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");

    property p_slverr_with_ready;
        pslverr |-> pready && psel && penable;
    endproperty
    a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("pslverr outside access");

    property p_byte_wide;
        pready |-> prdata[31:8] == 24'h000000;
    endproperty
    a_byte_wide: assert property (p_byte_wide) else $error("prdata upper bits set");

    property p_prdata_hold;
        !(psel && penable) |=> $stable(prdata);
    endproperty
    a_prdata_hold: assert property (p_prdata_hold) else $error("prdata moved between accesses");

    // Pin drive may only start after a host read or a register write
    property p_oe_cause;
        $rose(|data_pin_oe) |-> (|rd_hist_r) || (|wr_hist_r);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data pins driven without cause");

    property p_irq_cause;
        $rose(irq) |-> (|sel_hist_r) || (|wr_hist_r);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("irq without transfer");

    property p_latch_out_cause;
        $changed({data_pin_out, ctrl_pin_out}) |-> |wr_hist_r;
    endproperty
    a_latch_out_cause: assert property (p_latch_out_cause) else $error("latch output changed");

    c_irq: cover property ($rose(irq));
    c_host_read: cover property ($rose(|data_pin_oe) && |rd_hist_r);
    c_refused: cover property (pready && pslverr);
endmodule
`default_nettype wire

/* test/pshp_host_model.sv */
// Behavioural external microprocessor on the strobe pins and data bus
`timescale 1ns/1ps
`default_nettype none
module pshp_host_model (
    // Clock
    input  wire logic       mclk,
    // Bus toward the device
    output logic      [2:0] ctrl,
    output logic      [7:0] data,
    input  wire logic [7:0] bus
);
    initial begin
        ctrl = 3'h7;
        data = 8'h00;
    end
    // Strobe held for h clocks; afterwards the bus shows the inverse so stale data never matches
    task automatic xfer(input logic s, input logic w, input logic [7:0] d, input int h,
                        output logic [7:0] q);
        @(posedge mclk);
        data <= d;
        repeat (3) @(posedge mclk);
        // s is the select pin level, so zero selects the device
        ctrl <= {s, ~w, w};
        repeat (h) @(posedge mclk);
        q = bus;
        ctrl <= 3'h7;
        repeat (2) @(posedge mclk);
        data <= ~d;
        repeat (6) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the parallel host slave port
`timescale 1ns/1ps
`default_nettype none
module tb;
    import pshp_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rv;
    logic        pready, pslverr, irq, ev;
    logic [7:0]  dout, doe, hdata, bus, b, q;
    logic [2:0]  cout, coe, hctrl, cin;
    logic [31:0] lfsr = 32'h9314;
    int          fails = 0;
    int          checks = 0;

    always #25 mclk = ~mclk;
    assign bus = (doe & dout) | (~doe & hdata);
    assign cin = (coe & cout) | (~coe & hctrl);

    pshp_top dut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .data_pin_in(bus), .data_pin_out(dout), .data_pin_oe(doe),
        .ctrl_pin_in(cin), .ctrl_pin_out(cout), .ctrl_pin_oe(coe));
    pshp_host_model hm (.mclk(mclk), .ctrl(hctrl), .data(hdata), .bus(bus));

    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction
    // Status in host mode with all three control pins as inputs
    function automatic logic [7:0] stat(input logic ip, input logic op, input logic ov);
        return {ip, op, ov, 5'h17};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {lfsr[31:8], d};
        @(posedge mclk);
        penable <= 1'b1;
        // Values read here are those that stood just before the rising edge
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input string n, input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, i, 8'h00);
        chk(n, rv, {24'h0, e});
    endtask
    task automatic hx(input logic s, input logic w, input logic [7:0] d);
        hm.xfer(s, w, d, 5 + int'(rnd() & 8'h07), q);
    endtask
    task automatic irqchk(input logic e);
        repeat (2) @(negedge mclk);
        chk("irq", irq, e);
    endtask
    task automatic print_verdict;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd("status", PSHP_IDX_DIR_HOST_STATUS, 8'h07);
        rd("flags", PSHP_IDX_IRQ_FLAGS_1, 8'h00);
        rd("enables", PSHP_IDX_IRQ_ENABLES_1, 8'h00);
        rd("conv", PSHP_IDX_CONVERTER_CONFIG, 8'h00);
        rd("dir", PSHP_IDX_DATA_PORT_DIR, 8'hFF);
        apb(1'b1, 10'h3FF, 8'h5A);
        chk("wr_err", ev, 1'b1);
        rd("unmapped", 10'h3FF, 8'h00);
        chk("rd_err", ev, 1'b1);
        // General I/O mode: latches reach the pins, strobes are ignored
        b = rnd();
        apb(1'b1, PSHP_IDX_DATA_PORT_DIR, 8'h00);
        apb(1'b1, PSHP_IDX_DATA_PORT_LATCH, b);
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h00);
        apb(1'b1, PSHP_IDX_CONTROL_PIN_PORT, 8'h05);
        repeat (2) @(negedge mclk);
        chk("gpio_pins", {doe, dout}, {8'hFF, b});
        chk("ctrl_pins", {coe, cout}, 6'h3D);
        apb(1'b1, PSHP_IDX_DATA_PORT_DIR, 8'hFF);
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h07);
        hx(1'b0, 1'b1, b);
        rd("gpio_status", PSHP_IDX_DIR_HOST_STATUS, 8'h07);
        // Host mode
        b = rnd();
        apb(1'b1, PSHP_IDX_CONVERTER_CONFIG, b);
        rd("conv_rw", PSHP_IDX_CONVERTER_CONFIG, b);
        // Host mode must keep the control pins undriven even with output directions
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h10);
        repeat (2) @(negedge mclk);
        chk("ctrl_oe", coe, 3'h0);
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h17);
        rd("mode", PSHP_IDX_DIR_HOST_STATUS, stat(0, 0, 0));
        b = rnd();
        hx(1'b0, 1'b1, b);
        rd("in_pend", PSHP_IDX_DIR_HOST_STATUS, stat(1, 0, 0));
        rd("flag", PSHP_IDX_IRQ_FLAGS_1, 8'h80);
        rd("host_byte", PSHP_IDX_DATA_PORT_LATCH, b);
        rd("in_clr", PSHP_IDX_DIR_HOST_STATUS, stat(0, 0, 0));
        hx(1'b0, 1'b1, rnd());
        hx(1'b0, 1'b1, rnd());
        rd("overrun", PSHP_IDX_DIR_HOST_STATUS, stat(1, 0, 1));
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h37);
        rd("ov_keep", PSHP_IDX_DIR_HOST_STATUS, stat(1, 0, 1));
        apb(1'b1, PSHP_IDX_DIR_HOST_STATUS, 8'h17);
        rd("ov_clr", PSHP_IDX_DIR_HOST_STATUS, stat(1, 0, 0));
        apb(1'b0, PSHP_IDX_DATA_PORT_LATCH, 8'h00);
        hx(1'b1, 1'b1, rnd());
        hx(1'b1, 1'b0, rnd());
        rd("deselect", PSHP_IDX_DIR_HOST_STATUS, stat(0, 0, 0));
        apb(1'b1, PSHP_IDX_IRQ_FLAGS_1, 8'h80);
        rd("flag_clr", PSHP_IDX_IRQ_FLAGS_1, 8'h00);
        apb(1'b1, PSHP_IDX_IRQ_ENABLES_1, 8'h80);
        irqchk(1'b0);
        for (int k = 0; k < 4; k++) begin
            b = rnd();
            apb(1'b1, PSHP_IDX_DATA_PORT_LATCH, b);
            rd("out_pend", PSHP_IDX_DIR_HOST_STATUS, stat(0, 1, 0));
            hx(1'b0, 1'b0, ~b);
            chk("host_rd", q, b);
            chk("oe_off", doe, 8'h00);
            irqchk(1'b1);
            rd("out_clr", PSHP_IDX_DIR_HOST_STATUS, stat(0, 0, 0));
            apb(1'b1, PSHP_IDX_IRQ_FLAGS_1, 8'h80);
            irqchk(1'b0);
        end
        hx(1'b0, 1'b1, rnd());
        irqchk(1'b1);
        apb(1'b1, PSHP_IDX_IRQ_ENABLES_1, 8'h00);
        irqchk(1'b0);
        rd("masked", PSHP_IDX_IRQ_FLAGS_1, 8'h80);
        apb(1'b1, PSHP_IDX_IRQ_ENABLES_1, 8'h80);
        irqchk(1'b1);
        apb(1'b1, PSHP_IDX_IRQ_FLAGS_1, 8'h80);
        irqchk(1'b0);
        print_verdict();
    end

    // Whole run needs a few hundred clocks
    initial begin
        repeat (20000) @(posedge mclk);
        fails++;
        print_verdict();
    end
endmodule

bind pshp_top pshp_assertions u_chk (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe), .ctrl_pin_in(ctrl_pin_in),
    .ctrl_pin_out(ctrl_pin_out));
`default_nettype wire
